// *** src/link_diag_pkg.sv ***
// Shared constants for the link frame diagnostics block: register indices,
// flag bit positions, reset values and bus response codes.
// Assumes one 32-bit AXI4-Lite register bus, one word per register index.
package link_diag_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [13:0] CMD_ERR_IDX    = 14'h0787; // low_side_command_errors
  localparam logic [13:0] RSP_ERR_IDX    = 14'h0788; // low_side_response_errors
  localparam logic [13:0] HOST_DISC_IDX  = 14'h0789; // host_serial_discard_count
  localparam logic [13:0] HIGH_DISC_IDX  = 14'h078A; // high_side_discard_count
  localparam logic [13:0] LOW_DISC_IDX   = 14'h078B; // low_side_discard_count
  localparam logic [13:0] HOST_VHI_IDX   = 14'h078C;
  localparam logic [13:0] HOST_VLO_IDX   = 14'h078D;
  localparam logic [13:0] HIGH_VHI_IDX   = 14'h078E;
  localparam logic [13:0] HIGH_VLO_IDX   = 14'h078F;
  localparam logic [13:0] LOW_VHI_IDX    = 14'h0790;
  localparam logic [13:0] LOW_VLO_IDX    = 14'h0791;
  localparam logic [13:0] IRQ_STAT_IDX   = 14'h07B0;
  localparam logic [13:0] IRQ_MASK_IDX   = 14'h07B1;
  localparam logic [13:0] CTRL_IDX       = 14'h07B2;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CRC_BIT   = 0; // Shared by command and response flags
  localparam int UNEXP_BIT = 1;
  localparam int BYTE_BIT  = 2;
  localparam int SOF_BIT   = 3;
  localparam int TXDIS_BIT = 4;
  localparam int IERR_BIT  = 5; // Command register only
  localparam int WAIT_BIT  = 5; // Response register only
  localparam int ST_CMD    = 0; // Interrupt status bits
  localparam int ST_RSP    = 1;
  localparam int ST_HOST   = 2;
  localparam int ST_HIGH   = 3;
  localparam int ST_LOW    = 4;
  localparam int ST_W      = 5;
  localparam int DIR_BIT   = 0; // Control register: direction select

  // ****************************************************************
  // Reset values and bus codes
  // ****************************************************************
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [4:0] MASK_RST = 5'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// *** src/frame_counter.sv ***
// One port's discard and valid-frame counters with their read latches.
// Assumes single-cycle event pulses and a latch pulse on the same clock.
`timescale 1ns/10ps
module frame_counter
  import link_diag_pkg::*;
#(
  parameter int DISC_W  = 8,
  parameter int VALID_W = 16
) (
  input  wire logic               i_clk,
  input  wire logic               i_rstn,
  input  wire logic               i_discard,
  input  wire logic               i_valid,
  input  wire logic               i_latch,
  output logic [DISC_W-1:0]       o_disc_live,
  output logic [DISC_W-1:0]       o_disc_lat,
  output logic [VALID_W-1:0]      o_valid_lat
);

  typedef struct packed {
    logic [DISC_W-1:0]  disc;
    logic [VALID_W-1:0] valid;
    logic [DISC_W-1:0]  disc_lat;
    logic [VALID_W-1:0] valid_lat;
  } cnt_state_t;

  cnt_state_t q;
  cnt_state_t d;

  // ****************************************************************
  // Counting, saturation and latch-then-clear
  // ****************************************************************
  always_comb begin
    d = q;
    if (i_latch) begin
      d.disc_lat  = q.disc;                                    // RULE_13
      d.valid_lat = q.valid;                                   // RULE_13
      d.disc      = DISC_W'(i_discard);                        // Event in latch cycle kept
      d.valid     = VALID_W'(i_valid);
    end else begin
      if (i_discard && (q.disc != {DISC_W{1'b1}})) begin
        d.disc = q.disc + DISC_W'(1);                          // RULE_15
      end
      if (i_valid && (q.valid != {VALID_W{1'b1}})) begin
        d.valid = q.valid + VALID_W'(1);                       // RULE_14
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_disc_live = q.disc;
  assign o_disc_lat  = q.disc_lat;
  assign o_valid_lat = q.valid_lat;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_disc_sat;
    @(posedge i_clk) disable iff (!i_rstn)
      (!i_latch && i_discard && q.disc == {DISC_W{1'b1}}) |=> q.disc == {DISC_W{1'b1}};
  endproperty
  a_disc_sat: assert property (p_disc_sat) else $error("discard count wrapped"); // RULE_15

  property p_latch;
    @(posedge i_clk) disable iff (!i_rstn)
      i_latch |=> (q.disc_lat == $past(q.disc)) && (q.valid_lat == $past(q.valid))
                  && (q.disc <= DISC_W'(1));
  endproperty
  a_latch: assert property (p_latch) else $error("latch on read failed"); // RULE_13

endmodule // frame_counter

// *** src/link_frame_diag.sv ***
// Link frame error flags and discard/valid counters behind an AXI4-Lite slave.
// Assumes frame event pulses from link logic on the same clock as the bus.
//
// What this block does
// RULE_01: Low-side command CRC drop sets only CRC flag
// RULE_02: New command during response wait sets abort flag
// RULE_03: Abort flag armed only after broadcast/stack read
// RULE_04: Direction 1, tx disabled: flag and discard response
// RULE_05: Direction 1: unexpected start bit flags response
// RULE_06: Direction 1: faulty response byte sets byte flag
// RULE_07: Direction 0: low-side response is unexpected, flagged
// RULE_08: Response CRC drop sets CRC flag, hides others
// RULE_09: Bad last CRC byte sets CRC and byte
// RULE_10: Host serial port 8-bit discard count
// RULE_11: High-side port 8-bit discard count
// RULE_12: Low-side port 8-bit discard count
// RULE_13: Discard read latches counts, then clears counters
// RULE_14: Valid-frame counter 16 bits, saturating at all-ones
// RULE_15: Discard counters saturate instead of wrapping
// RULE_16: Command flags mirror response flags, one when seen
`timescale 1ns/10ps
module link_frame_diag
  import link_diag_pkg::*;
#(
  parameter int ADDR_W = 16
) (
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [31:0]       i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [31:0]            o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // Low-side frame end and its qualifiers
  input  wire logic              i_low_done,
  input  wire logic              i_low_is_rsp,
  input  wire logic              i_crc_bad,
  input  wire logic              i_last_crc_byte_bad,
  input  wire logic              i_sof_bad,
  input  wire logic              i_byte_bad,
  input  wire logic              i_init_bad,
  input  wire logic              i_low_tx_off,
  // Response wait tracking
  input  wire logic              i_stack_read_cmd,
  input  wire logic              i_rsp_waiting,
  input  wire logic              i_new_cmd,
  // Other ports' frame events
  input  wire logic              i_host_discard,
  input  wire logic              i_host_valid,
  input  wire logic              i_high_discard,
  input  wire logic              i_high_valid,
  output logic                   o_irq
);

  typedef struct packed {
    logic             aw_got;
    logic [13:0]      aw_idx;
    logic             w_got;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             awready;
    logic             wready;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [1:0]       rresp;
    logic [31:0]      rdata;
    logic [7:0]       cmd_flags;
    logic [7:0]       rsp_flags;
    logic             armed;
    logic [ST_W-1:0]  status;
    logic [ST_W-1:0]  mask;
    logic [7:0]       ctrl;
    logic             irq;
  } state_t;

  state_t      q;
  state_t      d;
  logic [7:0]  cmd_set;
  logic [7:0]  rsp_set;
  logic        low_disc;
  logic        low_valid;
  logic        abort;
  logic        ar_fire;
  logic [13:0] ar_idx;
  logic        lat_host;
  logic        lat_high;
  logic        lat_low;
  logic [7:0]  host_live;
  logic [7:0]  high_live;
  logic [7:0]  low_live;
  logic [7:0]  host_dlat;
  logic [7:0]  high_dlat;
  logic [7:0]  low_dlat;
  logic [15:0] host_vlat;
  logic [15:0] high_vlat;
  logic [15:0] low_vlat;

  // ****************************************************************
  // Per-port counters
  // ****************************************************************
  frame_counter #(.DISC_W(8), .VALID_W(16)) u_host_cnt (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_discard   (i_host_discard),       // RULE_10
    .i_valid     (i_host_valid),
    .i_latch     (lat_host),
    .o_disc_live (host_live),
    .o_disc_lat  (host_dlat),
    .o_valid_lat (host_vlat)
  );

  frame_counter #(.DISC_W(8), .VALID_W(16)) u_high_cnt (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_discard   (i_high_discard),       // RULE_11
    .i_valid     (i_high_valid),
    .i_latch     (lat_high),
    .o_disc_live (high_live),
    .o_disc_lat  (high_dlat),
    .o_valid_lat (high_vlat)
  );

  frame_counter #(.DISC_W(8), .VALID_W(16)) u_low_cnt (
    .i_clk       (i_clk),
    .i_rstn      (i_rstn),
    .i_discard   (low_disc),             // RULE_12
    .i_valid     (low_valid),
    .i_latch     (lat_low),
    .o_disc_live (low_live),
    .o_disc_lat  (low_dlat),
    .o_valid_lat (low_vlat)
  );

  // ****************************************************************
  // Low-side frame classification
  // ****************************************************************
  always_comb begin
    cmd_set   = 8'h00;
    rsp_set   = 8'h00;
    low_disc  = 1'b0;
    low_valid = 1'b0;
    abort     = q.armed && i_rsp_waiting && i_new_cmd;             // RULE_03
    rsp_set[WAIT_BIT] = abort;                                      // RULE_02
    if (i_low_done) begin
      if (i_low_is_rsp) begin
        if (i_crc_bad) begin
          rsp_set[CRC_BIT]  = 1'b1;                                 // RULE_08
          rsp_set[BYTE_BIT] = i_last_crc_byte_bad;                  // RULE_09
          low_disc          = 1'b1;
        end else if (!q.ctrl[DIR_BIT]) begin
          rsp_set[UNEXP_BIT] = 1'b1;                                // RULE_07
          low_disc           = 1'b1;
        end else begin
          rsp_set[SOF_BIT]   = i_sof_bad;                           // RULE_05
          rsp_set[BYTE_BIT]  = i_byte_bad;                          // RULE_06
          rsp_set[TXDIS_BIT] = i_low_tx_off;                        // RULE_04
          low_disc  = i_sof_bad || i_byte_bad || i_low_tx_off;
          low_valid = !low_disc;
        end
      end else begin
        if (i_crc_bad) begin
          cmd_set[CRC_BIT] = 1'b1;                                  // RULE_01
          low_disc         = 1'b1;
        end else if (q.ctrl[DIR_BIT]) begin
          cmd_set[UNEXP_BIT] = 1'b1;                                // RULE_16
          low_disc           = 1'b1;
        end else begin
          cmd_set[SOF_BIT]   = i_sof_bad;                           // RULE_16
          cmd_set[BYTE_BIT]  = i_byte_bad;
          cmd_set[IERR_BIT]  = i_init_bad;
          cmd_set[TXDIS_BIT] = i_low_tx_off;
          low_disc  = i_sof_bad || i_byte_bad || i_init_bad || i_low_tx_off;
          low_valid = !low_disc;
        end
      end
    end
  end

  // Read decode and read side effects
  assign ar_fire  = i_arvalid && q.arready;
  assign ar_idx   = i_araddr[15:2];
  assign lat_host = ar_fire && (ar_idx == HOST_DISC_IDX);          // RULE_13
  assign lat_high = ar_fire && (ar_idx == HIGH_DISC_IDX);
  assign lat_low  = ar_fire && (ar_idx == LOW_DISC_IDX);

  // ****************************************************************
  // Next state: bus slave, flags, interrupt
  // ****************************************************************
  always_comb begin
    d = q;
    // Write address and data taken in either order
    if (i_awvalid && q.awready) begin
      d.aw_got = 1'b1;
      d.aw_idx = i_awaddr[15:2];
    end
    if (i_wvalid && q.wready) begin
      d.w_got = 1'b1;
      d.wdata = i_wdata;
      d.wstrb = i_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = RESP_OKAY;
      unique case (q.aw_idx)
        IRQ_MASK_IDX: begin
          if (q.wstrb[0]) d.mask = q.wdata[ST_W-1:0];
        end
        CTRL_IDX: begin
          if (q.wstrb[0]) d.ctrl = q.wdata[7:0];
        end
        CMD_ERR_IDX, RSP_ERR_IDX, HOST_DISC_IDX, HIGH_DISC_IDX, LOW_DISC_IDX,
        HOST_VHI_IDX, HOST_VLO_IDX, HIGH_VHI_IDX, HIGH_VLO_IDX, LOW_VHI_IDX,
        LOW_VLO_IDX, IRQ_STAT_IDX: begin
          d.bresp = RESP_OKAY; // Read-only, write ignored
        end
        default: d.bresp = RESP_DECERR;
      endcase
    end
    if (q.bvalid && i_bready) d.bvalid = 1'b0;
    d.awready = !d.aw_got && !d.bvalid;
    d.wready  = !d.w_got && !d.bvalid;

    // Flags: read clears, a same-cycle set wins
    d.cmd_flags = cmd_set;
    d.rsp_flags = rsp_set;
    d.status    = {low_disc, i_high_discard, i_host_discard, |rsp_set, |cmd_set};
    if (!(ar_fire && ar_idx == CMD_ERR_IDX)) d.cmd_flags = d.cmd_flags | q.cmd_flags;
    if (!(ar_fire && ar_idx == RSP_ERR_IDX)) d.rsp_flags = d.rsp_flags | q.rsp_flags;
    if (!(ar_fire && ar_idx == IRQ_STAT_IDX)) d.status = d.status | q.status;
    d.armed = i_stack_read_cmd || (q.armed && !abort);             // RULE_03

    // Read channel
    if (ar_fire) begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      d.rdata  = 32'h00000000;
      unique case (ar_idx)
        CMD_ERR_IDX:   d.rdata[7:0] = q.cmd_flags;
        RSP_ERR_IDX:   d.rdata[7:0] = q.rsp_flags;
        HOST_DISC_IDX: d.rdata[7:0] = host_live;
        HIGH_DISC_IDX: d.rdata[7:0] = high_live;
        LOW_DISC_IDX:  d.rdata[7:0] = low_live;
        HOST_VHI_IDX:  d.rdata[7:0] = host_vlat[15:8];
        HOST_VLO_IDX:  d.rdata[7:0] = host_vlat[7:0];
        HIGH_VHI_IDX:  d.rdata[7:0] = high_vlat[15:8];
        HIGH_VLO_IDX:  d.rdata[7:0] = high_vlat[7:0];
        LOW_VHI_IDX:   d.rdata[7:0] = low_vlat[15:8];
        LOW_VLO_IDX:   d.rdata[7:0] = low_vlat[7:0];
        IRQ_STAT_IDX:  d.rdata[ST_W-1:0] = q.status;
        IRQ_MASK_IDX:  d.rdata[ST_W-1:0] = q.mask;
        CTRL_IDX:      d.rdata[7:0] = q.ctrl;
        default:       d.rresp = RESP_DECERR;
      endcase
    end
    if (q.rvalid && i_rready) d.rvalid = 1'b0;
    d.arready = !d.rvalid;
    d.irq     = |(d.status & d.mask);
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      q           <= '0;
      q.cmd_flags <= FLAG_RST;
      q.rsp_flags <= FLAG_RST;
      q.mask      <= MASK_RST;
      q.ctrl      <= CTRL_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign o_awready = q.awready;
  assign o_wready  = q.wready;
  assign o_bvalid  = q.bvalid;
  assign o_bresp   = q.bresp;
  assign o_arready = q.arready;
  assign o_rvalid  = q.rvalid;
  assign o_rresp   = q.rresp;
  assign o_rdata   = q.rdata;
  assign o_irq     = q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_cmd_crc;
    (i_low_done && !i_low_is_rsp && i_crc_bad && !i_arvalid)
      |=> q.cmd_flags[CRC_BIT] && (q.cmd_flags[5:1] == $past(q.cmd_flags[5:1]));
  endproperty
  a_cmd_crc: assert property (p_cmd_crc) else $error("command CRC flag wrong"); // RULE_01

  property p_wait;
    (q.armed && i_rsp_waiting && i_new_cmd) |=> q.rsp_flags[WAIT_BIT] && !q.armed;
  endproperty
  a_wait: assert property (p_wait) else $error("wait abort not flagged"); // RULE_02

  property p_wait_armed;
    (!q.armed && !q.rsp_flags[WAIT_BIT]) |=> !q.rsp_flags[WAIT_BIT];
  endproperty
  a_wait_armed: assert property (p_wait_armed) else $error("abort flag without read"); // RULE_03

  property p_txdis;
    (i_low_done && i_low_is_rsp && q.ctrl[DIR_BIT] && !i_crc_bad && i_low_tx_off)
      |=> q.rsp_flags[TXDIS_BIT] && q.status[ST_LOW];
  endproperty
  a_txdis: assert property (p_txdis) else $error("tx disabled not flagged"); // RULE_04

  property p_sof;
    (i_low_done && i_low_is_rsp && q.ctrl[DIR_BIT] && !i_crc_bad && i_sof_bad)
      |=> q.rsp_flags[SOF_BIT];
  endproperty
  a_sof: assert property (p_sof) else $error("start flag missed"); // RULE_05

  property p_byte;
    (i_low_done && i_low_is_rsp && q.ctrl[DIR_BIT] && !i_crc_bad && i_byte_bad)
      |=> q.rsp_flags[BYTE_BIT];
  endproperty
  a_byte: assert property (p_byte) else $error("byte flag missed"); // RULE_06

  property p_unexp;
    (i_low_done && i_low_is_rsp && !q.ctrl[DIR_BIT] && !i_crc_bad)
      |=> q.rsp_flags[UNEXP_BIT] && !$past(low_valid);
  endproperty
  a_unexp: assert property (p_unexp) else $error("unexpected response missed"); // RULE_07

  property p_rsp_crc;
    (i_low_done && i_low_is_rsp && i_crc_bad && !i_arvalid)
      |=> q.rsp_flags[CRC_BIT] && (q.rsp_flags[BYTE_BIT] == ($past(q.rsp_flags[BYTE_BIT])
          || $past(i_last_crc_byte_bad))) && !$past(q.rsp_flags[SOF_BIT]) == !q.rsp_flags[SOF_BIT];
  endproperty
  a_rsp_crc: assert property (p_rsp_crc) else $error("response CRC flags wrong"); // RULE_08

  property p_crc_last;
    (i_low_done && i_low_is_rsp && i_crc_bad && i_last_crc_byte_bad)
      |=> q.rsp_flags[CRC_BIT] && q.rsp_flags[BYTE_BIT];
  endproperty
  a_crc_last: assert property (p_crc_last) else $error("CRC byte pair missed"); // RULE_09

  property p_low_count;
    (low_disc && !lat_low && low_live != 8'hFF) |=> low_live == $past(low_live) + 8'h01;
  endproperty
  a_low_count: assert property (p_low_count) else $error("low discard miscount"); // RULE_12

  property p_irq;
    (q.status & q.mask) != 5'h00 |-> q.irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");

  c_wait_abort: cover property (q.armed && i_rsp_waiting && i_new_cmd);
  c_latch_low:  cover property (lat_low && low_live != 8'h00);
  c_crc_both:   cover property (i_low_done && i_low_is_rsp && i_crc_bad && i_last_crc_byte_bad);
  c_irq:        cover property (q.irq ##1 !q.irq);

endmodule // link_frame_diag

// *** testbench/link_partner.sv ***
// Far-side model of the low-side link: one frame end per bench request.
// Assumes requests arrive just after a rising edge of the device clock.
`timescale 1ns/10ps
module link_partner (
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  input  wire logic       i_send,
  input  wire logic       i_rsp,
  input  wire logic [5:0] i_q,
  output logic            o_done,
  output logic            o_is_rsp,
  output logic [5:0]      o_q
);
  // Frame end pulse; qualifiers invert between frames so stale values never match
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_done <= 1'b0;
      o_is_rsp <= 1'b0;
      o_q <= 6'h00;
    end else begin
      o_done <= i_send;
      o_is_rsp <= i_send ? i_rsp : ~o_is_rsp;
      o_q <= i_send ? i_q : ~o_q;
    end
  end
endmodule // link_partner

// *** testbench/testbench.sv ***
// Self-checking bench for link_frame_diag: bus tasks, frame errors, counters, interrupt.
// Assumes link_partner drives the low-side frame ends; other events come from here.
`timescale 1ns/10ps
module testbench;
  import link_diag_pkg::*;
  logic        i_clk = 0, i_rstn = 0;
  logic [15:0] awaddr = 0, araddr = 0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, got;
  logic [5:0]  ev = 0, fq = 0, q;
  logic        send = 0, rsp = 0, waiting = 0, r;
  logic [1:0]  resp, o_bresp, o_rresp;
  logic        o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  logic [31:0] o_rdata;
  logic        done, is_rsp;
  logic [5:0]  pq;
  logic [7:0]  e;
  int          fails = 0, total_checks = 0, cycles = 0, ndisc = 0, n;
  logic [5:0]  hand [4] = '{6'h0D, 6'h03, 6'h30, 6'h0D};

  always #2 i_clk = ~i_clk;

  link_partner link_partner_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_send(send), .i_rsp(rsp),
    .i_q(fq), .o_done(done), .o_is_rsp(is_rsp), .o_q(pq));

  link_frame_diag link_frame_diag_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_awaddr(awaddr),
    .i_awvalid(awvalid), .o_awready(o_awready), .i_wdata(wdata), .i_wstrb(4'hF),
    .i_wvalid(wvalid), .o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid),
    .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(o_arready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(rready),
    .i_low_done(done), .i_low_is_rsp(is_rsp), .i_crc_bad(pq[0]),
    .i_last_crc_byte_bad(pq[1]), .i_sof_bad(pq[2]), .i_byte_bad(pq[3]), .i_init_bad(pq[4]),
    .i_low_tx_off(pq[5]), .i_stack_read_cmd(ev[4]), .i_rsp_waiting(waiting),
    .i_new_cmd(ev[5]), .i_host_discard(ev[0]), .i_host_valid(ev[1]),
    .i_high_discard(ev[2]), .i_high_valid(ev[3]), .o_irq(o_irq));

  // ****************************************************************
  // Checking and bus tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    total_checks++;
    if (sn !== ex) begin
      $display("Error %s expected %h seen %h", nm, ex, sn);
      fails++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [13:0] ix, input logic [31:0] d, input logic [1:0] er);
    logic a, w;
    a = 1;
    w = 1;
    @(posedge i_clk);
    awaddr <= {ix, 2'b00};
    awvalid <= 1;
    wdata <= d;
    wvalid <= 1;
    bready <= 1;
    while (a || w) begin
      @(posedge i_clk);
      if (a && o_awready) begin
        a = 0;
        awvalid <= 0;
      end
      if (w && o_wready) begin
        w = 0;
        wvalid <= 0;
      end
    end
    while (!o_bvalid) @(posedge i_clk);
    bready <= 0;
    chk("bresp", {30'h0, er}, {30'h0, o_bresp});
  endtask

  task automatic rd(input logic [13:0] ix, output logic [31:0] d, output logic [1:0] rr);
    @(posedge i_clk);
    araddr <= {ix, 2'b00};
    arvalid <= 1;
    rready <= 1;
    do @(posedge i_clk); while (!o_arready);
    arvalid <= 0;
    do @(posedge i_clk); while (!o_rvalid);
    rready <= 0;
    d = o_rdata;
    rr = o_rresp;
  endtask

  // Read a register and compare data and response
  task automatic rc(input logic [13:0] ix, input logic [31:0] ex);
    rd(ix, got, resp);
    chk($sformatf("reg %h", ix), ex, got);
    chk("rresp", {30'h0, RESP_OKAY}, {30'h0, resp});
  endtask

  task automatic pulse(input int b, input int cnt);
    repeat (cnt) begin
      @(posedge i_clk);
      ev[b] <= 1;
      @(posedge i_clk);
      ev[b] <= 0;
    end
  endtask

  task automatic frame(input logic fr, input logic [5:0] fqv);
    @(posedge i_clk);
    send <= 1;
    rsp <= fr;
    fq <= fqv;
    @(posedge i_clk);
    send <= 0;
  endtask

  // Expected flag byte for one low-side frame
  function automatic logic [7:0] expf(input logic fr, input logic d, input logic [5:0] fqv);
    if (fqv[0]) return {5'h00, fr & fqv[1], 2'b01};
    if (fr != d) return 8'h02;
    return {2'b00, ~fr & fqv[4], fqv[5], fqv[2], fqv[3], 2'b00};
  endfunction

  // ****************************************************************
  // Main sequence and timeout
  // ****************************************************************
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails++;
      finish_test;
    end
  end

  initial begin
    void'($urandom(32'hC3F1));
    repeat (2) @(posedge i_clk);
    i_rstn <= 1;
    for (int i = 'h787; i <= 'h791; i++) rc(14'(i), 32'h0);
    rd(14'h07A0, got, resp);
    chk("unmapped rresp", {30'h0, RESP_DECERR}, {30'h0, resp});
    wr(CMD_ERR_IDX, 32'hFF, RESP_OKAY);
    wr(14'h07A0, 32'h0, RESP_DECERR);
    rc(CMD_ERR_IDX, 32'h0);
    $display("test registers done");
    for (int d = 0; d < 2; d++) begin
      wr(CTRL_IDX, 32'(d), RESP_OKAY);
      for (int k = 0; k < 16; k++) begin
        r = k[0];
        q = (d == 1 && k < 4) ? hand[k] : 6'($urandom);
        frame(r, q);
        rd(r ? RSP_ERR_IDX : CMD_ERR_IDX, got, resp);
        e = expf(r, d[0], q);
        ndisc += (e != 8'h00);
        chk("flags", {24'h0, e}, got);
      end
    end
    rc(LOW_DISC_IDX, 32'(ndisc));
    rc(LOW_VLO_IDX, 32'(32 - ndisc));
    rc(LOW_DISC_IDX, 32'h0);
    $display("test frames done");
    n = 1 + $urandom_range(40);
    pulse(0, n);
    pulse(1, 5);
    rc(HOST_DISC_IDX, 32'(n));
    rc(HOST_VLO_IDX, 32'h5);
    rc(HOST_VHI_IDX, 32'h0);
    rc(HOST_DISC_IDX, 32'h0);
    pulse(2, 260);
    pulse(3, 2);
    rc(HIGH_DISC_IDX, 32'hFF);
    rc(HIGH_VLO_IDX, 32'h2);
    rc(HIGH_DISC_IDX, 32'h0);
    $display("test counters done");
    waiting <= 1;
    pulse(5, 1);
    rc(RSP_ERR_IDX, 32'h0);
    pulse(4, 1);
    pulse(5, 1);
    rc(RSP_ERR_IDX, 32'h20);
    waiting <= 0;
    $display("test wait abort done");
    wr(IRQ_MASK_IDX, 32'h1 << ST_HOST, RESP_OKAY);
    rc(IRQ_MASK_IDX, 32'h1 << ST_HOST);
    // Host discards from the counter test are still pending in status
    chk("irq pending", 32'h1, {31'h0, o_irq});
    rd(IRQ_STAT_IDX, got, resp);
    chk("irq status all", 32'h1F, got);
    pulse(0, 1);
    repeat (3) @(posedge i_clk);
    chk("irq set", 32'h1, {31'h0, o_irq});
    rc(IRQ_STAT_IDX, 32'h1 << ST_HOST);
    repeat (3) @(posedge i_clk);
    chk("irq cleared", 32'h0, {31'h0, o_irq});
    pulse(2, 1);
    repeat (3) @(posedge i_clk);
    chk("irq masked", 32'h0, {31'h0, o_irq});
    rc(IRQ_STAT_IDX, 32'h1 << ST_HIGH);
    $display("test interrupt done");
    finish_test;
  end
endmodule // testbench
